// *** verilog/rgd_map.vh ***
// Register map, field positions, reset values and gain constants of the receive gain decoder.
`ifndef RGD_MAP_VH
`define RGD_MAP_VH

// ****************************************************************
// Register byte addresses (index times four)
// ****************************************************************
`define RGD_IDX_RXGAIN       5'd11
`define RGD_IDX_RXCFG        5'd15
`define RGD_ADDR_RXGAIN      12'h02c
`define RGD_ADDR_RXCFG       12'h03c
`define RGD_ADDR_STEPS       12'h040
`define RGD_ADDR_DCCFG       12'h044
`define RGD_ADDR_STATUS      12'h048
`define RGD_ADDR_TRIM        12'h04c

// ****************************************************************
// Field positions
// ****************************************************************
`define RGD_RXGAIN_LSB       0
`define RGD_RXGAIN_MSB       6
`define RGD_GAINCAL_LSB      0
`define RGD_GAINCAL_MSB      4
`define RGD_FMODE_LSB        8
`define RGD_FMODE_MSB        10
`define RGD_MIXSTEP_LSB      0
`define RGD_MIXSTEP_MSB      3
`define RGD_LNASTEP_LSB      4
`define RGD_LNASTEP_MSB      7
`define RGD_DCMODE_BIT       0
`define RGD_SLOWSH_LSB       1
`define RGD_SLOWSH_MSB       3
`define RGD_FASTSH_LSB       4
`define RGD_FASTSH_MSB       6
`define RGD_SETTLE_LSB       8
`define RGD_SETTLE_MSB       15

// ****************************************************************
// Reset values
// ****************************************************************
`define RGD_RST_RXGAIN       7'h00
`define RGD_RST_GAINCAL      5'h00
`define RGD_RST_FMODE        3'h0
`define RGD_RST_MIXSTEP      4'h0
`define RGD_RST_LNASTEP      4'h0
`define RGD_RST_DCCFG        16'h1042

// ****************************************************************
// Filter modes and gain constants in dB
// ****************************************************************
`define RGD_FMODE_WCDMA7     3'h0
`define RGD_FMODE_WCDMA5     3'h1
`define RGD_FMODE_GSM        3'h2
`define RGD_X_WCDMA          9'd8
`define RGD_X_GSM            9'd17
`define RGD_MIXBASE_WCDMA    9'd18
`define RGD_MIXBASE_GSM      9'd27
`define RGD_VGA_BASE_NEG     9'd6
`define RGD_RANGE_MAX        9'd90
`define RGD_RF_STEP          8'd6
`define RGD_FILT_STEP        8'd12
`define RGD_VGA_MAX          8'd24
`define RGD_FILT_THR         8'd25
`define RGD_MIX_THR_BASE     8'd30
`define RGD_LNA_THR_BASE     8'd48

`endif

// *** verilog/rgd_step_count.v ***
// Counts how many equally spaced gain thresholds a value has reached.
`timescale 1ns/10ps
`default_nettype none
module rgd_step_count #(
  parameter W       = 8,
  parameter STEPS   = 3,
  parameter SPACING = 6
) (
  input  wire [W-1:0] value,
  input  wire [W-1:0] thresh,
  output reg  [1:0]   count
);
  reg [W+1:0] point;
  integer     k;

  always @* begin
    count = 2'd0;
    point = {2'b00, thresh};
    for (k = 0; k < STEPS; k = k + 1) begin
      if ({2'b00, value} >= point) begin
        count = count + 2'd1;
      end
      point = point + SPACING[W+1:0];
    end
  end
endmodule
`default_nettype wire

// *** verilog/rgd_dc_chan.v ***
// One channel of the dc offset loop: integrates digitised offsets into a saturating trim word.
`timescale 1ns/10ps
`default_nettype none
module rgd_dc_chan #(
  parameter AW = 10,
  parameter TW = 8,
  parameter FW = 8
) (
  input  wire                 pclk,
  input  wire                 presetn,
  input  wire                 update,
  input  wire signed [AW-1:0] offset,
  input  wire [2:0]           shift,
  output wire signed [TW-1:0] trim
);
  localparam ACW = TW + FW;
  reg  signed [ACW-1:0] acc;
  wire signed [ACW+1:0] step_full;
  wire signed [ACW+1:0] next_sum;
  wire signed [ACW+1:0] acc_max;
  wire signed [ACW+1:0] acc_min;

  // The offset is scaled into the fraction so small residuals still move the trim.
  assign step_full = ($signed({{(ACW+2-AW){offset[AW-1]}}, offset}) <<< (FW - 2)) >>> shift;
  assign next_sum  = {{2{acc[ACW-1]}}, acc} - step_full;
  assign acc_max   = {3'b000, {(ACW-1){1'b1}}};
  assign acc_min   = {3'b111, {(ACW-1){1'b0}}};
  assign trim      = acc[ACW-1:FW];

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      acc <= {ACW{1'b0}};
    end else if (update) begin
      // Saturation keeps a large offset from wrapping the trim to the opposite sign.
      if (next_sum > acc_max) begin
        acc <= acc_max[ACW-1:0];
      end else if (next_sum < acc_min) begin
        acc <= acc_min[ACW-1:0];
      end else begin
        acc <= next_sum[ACW-1:0];
      end
    end
  end
endmodule
`default_nettype wire

// *** verilog/rgd_top.v ***
// Receive gain decoder with APB registers and the automatic dc offset loop.
//
// The placing of the registers and register access over APB are this design's own decisions.
`timescale 1ns/10ps
`default_nettype none
`include "rgd_map.vh"

module rgd_top #(
  parameter AW = 10,
  parameter TW = 8
) (
  input  wire                 pclk,
  input  wire                 presetn,
  input  wire                 psel,
  input  wire                 penable,
  input  wire                 pwrite,
  input  wire [11:0]          paddr,
  input  wire [31:0]          pwdata,
  input  wire [3:0]           pstrb,
  output wire                 pready,
  output reg  [31:0]          prdata,
  output wire                 pslverr,
  input  wire                 offset_valid,
  input  wire signed [AW-1:0] offset_i,
  input  wire signed [AW-1:0] offset_q,
  output reg  [1:0]           lna_code,
  output reg  [1:0]           mix_code,
  output reg  [1:0]           filt1_code,
  output reg  [1:0]           filt2_code,
  output reg  [4:0]           vga_code,
  output reg  [2:0]           filter_mode,
  output reg                  gain_change,
  output wire signed [TW-1:0] trim_i,
  output wire signed [TW-1:0] trim_q,
  output wire                 dc_busy
);

  // ****************************************************************
  // Loop states
  // ****************************************************************
  localparam ST_IDLE   = 2'd0;
  localparam ST_SETTLE = 2'd1;
  localparam ST_TRACK  = 2'd2;

  // ****************************************************************
  // Configuration registers
  // ****************************************************************
  reg  [6:0]  rx_gain;
  reg  [4:0]  gain_cal;
  reg  [3:0]  mix_step;
  reg  [3:0]  lna_step;
  reg  [15:0] dc_cfg;
  reg         gain_wr;
  reg  [8:0]  eff_gain;

  wire        setup    = psel & ~penable;
  wire        access   = psel & penable;
  wire        hit_gain = (paddr == `RGD_ADDR_RXGAIN);
  wire        hit_cfg  = (paddr == `RGD_ADDR_RXCFG);
  wire        hit_step = (paddr == `RGD_ADDR_STEPS);
  wire        hit_dc   = (paddr == `RGD_ADDR_DCCFG);
  wire        hit_stat = (paddr == `RGD_ADDR_STATUS);
  wire        hit_trim = (paddr == `RGD_ADDR_TRIM);
  wire        hit_rw   = hit_gain | hit_cfg | hit_step | hit_dc;
  wire        hit_any  = hit_rw | hit_stat | hit_trim;
  wire        bad      = ~hit_any | (pwrite & ~hit_rw);
  wire        wr_ok    = access & pwrite & ~bad;

  // Every access completes with no wait state; read data is caught in setup.
  assign pready  = 1'b1;
  assign pslverr = access & bad;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_gain     <= `RGD_RST_RXGAIN;
      gain_cal    <= `RGD_RST_GAINCAL;
      filter_mode <= `RGD_RST_FMODE;
      mix_step    <= `RGD_RST_MIXSTEP;
      lna_step    <= `RGD_RST_LNASTEP;
      dc_cfg      <= `RGD_RST_DCCFG;
      gain_wr     <= 1'b0;
    end else begin
      gain_wr <= 1'b0;
      if (wr_ok && hit_gain && pstrb[0]) begin
        rx_gain <= pwdata[`RGD_RXGAIN_MSB:`RGD_RXGAIN_LSB];
        gain_wr <= 1'b1;
      end
      if (wr_ok && hit_cfg) begin
        if (pstrb[0]) begin
          gain_cal <= pwdata[`RGD_GAINCAL_MSB:`RGD_GAINCAL_LSB];
        end
        if (pstrb[1]) begin
          filter_mode <= pwdata[`RGD_FMODE_MSB:`RGD_FMODE_LSB];
        end
        gain_wr <= pstrb[0] | pstrb[1];
      end
      if (wr_ok && hit_step && pstrb[0]) begin
        mix_step <= pwdata[`RGD_MIXSTEP_MSB:`RGD_MIXSTEP_LSB];
        lna_step <= pwdata[`RGD_LNASTEP_MSB:`RGD_LNASTEP_LSB];
      end
      if (wr_ok && hit_dc) begin
        if (pstrb[0]) begin
          dc_cfg[7:0] <= pwdata[7:0];
        end
        if (pstrb[1]) begin
          dc_cfg[15:8] <= pwdata[15:8];
        end
      end
    end
  end

  // ****************************************************************
  // Gain decode
  // ****************************************************************
  wire        is_gsm    = (filter_mode == `RGD_FMODE_GSM);
  wire [8:0]  x_const   = is_gsm ? `RGD_X_GSM : `RGD_X_WCDMA;
  wire [8:0]  mix_base  = is_gsm ? `RGD_MIXBASE_GSM : `RGD_MIXBASE_WCDMA;
  wire [8:0]  next_eff  = {2'b00, rx_gain} - {4'b0000, gain_cal} + x_const;
  // Headroom above the lowest reachable total, in dB.
  wire [8:0]  floor_g   = mix_base - `RGD_VGA_BASE_NEG;
  wire [8:0]  above     = next_eff - floor_g;
  wire        below_min = next_eff[8] | (next_eff < floor_g);
  wire [8:0]  range_max = `RGD_RANGE_MAX;
  reg  [7:0]  span;
  always @* begin
    if (below_min) begin
      span = 8'd0;
    end else if (above > range_max) begin
      span = range_max[7:0];
    end else begin
      span = above[7:0];
    end
  end

  wire [1:0]  lna_n;
  wire [1:0]  mix_n;
  wire [1:0]  filt_n;
  wire [7:0]  lna_thr = `RGD_LNA_THR_BASE + {4'h0, lna_step};
  wire [7:0]  mix_thr = `RGD_MIX_THR_BASE + {4'h0, mix_step};

  rgd_step_count #(.W(8), .STEPS(3), .SPACING(6)) u_lna (
    .value  (span),
    .thresh (lna_thr),
    .count  (lna_n)
  );

  rgd_step_count #(.W(8), .STEPS(2), .SPACING(6)) u_mix (
    .value  (span),
    .thresh (mix_thr),
    .count  (mix_n)
  );

  wire [7:0]  rf_gain = {3'b000, lna_n, 1'b0} * `RGD_RF_STEP / 8'd2 + {3'b000, mix_n, 1'b0} * `RGD_RF_STEP / 8'd2;
  wire [7:0]  bb_gain = (span > rf_gain) ? (span - rf_gain) : 8'd0;

  // Filter pair, 12 dB combined steps
  rgd_step_count #(.W(8), .STEPS(3), .SPACING(12)) u_filt (
    .value  (bb_gain),
    .thresh (`RGD_FILT_THR),
    .count  (filt_n)
  );

  wire [7:0]  filt_gain = {4'h0, filt_n, 2'b00} * 8'd3;
  wire [7:0]  vga_rest  = bb_gain - filt_gain;
  // VGA remainder in 1 dB, clipped
  wire [7:0]  vga_clip  = (vga_rest > `RGD_VGA_MAX) ? `RGD_VGA_MAX : vga_rest;
  wire [4:0]  next_vga  = vga_clip[4:0];

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lna_code    <= 2'd0;
      mix_code    <= 2'd0;
      filt1_code  <= 2'd0;
      filt2_code  <= 2'd0;
      vga_code    <= 5'd0;
      eff_gain    <= 9'd0;
      gain_change <= 1'b0;
    end else begin
      lna_code    <= lna_n;
      mix_code    <= mix_n;
      // Both filter stages share one code
      filt1_code  <= filt_n;
      filt2_code  <= filt_n;
      vga_code    <= next_vga;
      eff_gain    <= next_eff;
      gain_change <= gain_wr;
    end
  end

  // ****************************************************************
  // Dc offset loop control
  // ****************************************************************
  reg  [1:0]  loop_st;
  reg  [1:0]  next_loop_st;
  reg  [7:0]  settle_cnt;
  reg  [7:0]  next_settle_cnt;
  wire        hpf_mode  = dc_cfg[`RGD_DCMODE_BIT];
  wire [7:0]  settle_n  = dc_cfg[`RGD_SETTLE_MSB:`RGD_SETTLE_LSB];
  wire [2:0]  slow_sh   = dc_cfg[`RGD_SLOWSH_MSB:`RGD_SLOWSH_LSB];
  wire [2:0]  fast_sh   = dc_cfg[`RGD_FASTSH_MSB:`RGD_FASTSH_LSB];
  wire        loop_upd  = offset_valid & (loop_st != ST_IDLE);
  // Fast settling is an HPF feature; the servo always integrates at its own rate.
  wire [2:0]  loop_sh   = (hpf_mode && loop_st == ST_SETTLE) ? fast_sh : slow_sh;

  assign dc_busy = (loop_st == ST_SETTLE);

  always @* begin
    next_loop_st    = loop_st;
    next_settle_cnt = settle_cnt;
    case (loop_st)
      ST_IDLE: begin
        if (hpf_mode) begin
          next_loop_st = ST_TRACK;
        end
      end
      ST_SETTLE: begin
        if (offset_valid) begin
          if (settle_cnt <= 8'd1) begin
            next_settle_cnt = 8'd0;
            next_loop_st    = hpf_mode ? ST_TRACK : ST_IDLE;
          end else begin
            next_settle_cnt = settle_cnt - 8'd1;
          end
        end
      end
      ST_TRACK: begin
        if (!hpf_mode) begin
          next_loop_st = ST_IDLE;
        end
      end
      default: begin
        next_loop_st    = ST_IDLE;
        next_settle_cnt = 8'd0;
      end
    endcase
    if (gain_change && settle_n != 8'd0) begin
      next_loop_st    = ST_SETTLE;
      next_settle_cnt = settle_n;
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      loop_st    <= ST_IDLE;
      settle_cnt <= 8'd0;
    end else begin
      loop_st    <= next_loop_st;
      settle_cnt <= next_settle_cnt;
    end
  end

  rgd_dc_chan #(.AW(AW), .TW(TW), .FW(8)) u_dc_i (
    .pclk    (pclk),
    .presetn (presetn),
    .update  (loop_upd),
    .offset  (offset_i),
    .shift   (loop_sh),
    .trim    (trim_i)
  );

  rgd_dc_chan #(.AW(AW), .TW(TW), .FW(8)) u_dc_q (
    .pclk    (pclk),
    .presetn (presetn),
    .update  (loop_upd),
    .offset  (offset_q),
    .shift   (loop_sh),
    .trim    (trim_q)
  );

  // ****************************************************************
  // Read data
  // ****************************************************************
  reg [31:0] next_rdata;
  always @* begin
    next_rdata = 32'h0000_0000;
    if (hit_gain) begin
      next_rdata[6:0] = rx_gain;
    end else if (hit_cfg) begin
      next_rdata[4:0]  = gain_cal;
      next_rdata[10:8] = filter_mode;
    end else if (hit_step) begin
      next_rdata[7:0] = {lna_step, mix_step};
    end else if (hit_dc) begin
      next_rdata[15:0] = dc_cfg;
    end else if (hit_stat) begin
      next_rdata[4:0]   = vga_code;
      next_rdata[6:5]   = filt1_code;
      next_rdata[8:7]   = mix_code;
      next_rdata[10:9]  = lna_code;
      next_rdata[11]    = dc_busy;
      next_rdata[13:12] = loop_st;
      next_rdata[24:16] = eff_gain;
    end else if (hit_trim) begin
      next_rdata[TW-1:0]    = trim_i;
      next_rdata[TW+7:8]    = trim_q;
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (setup && !pwrite) begin
      prdata <= next_rdata;
    end
  end
endmodule
`default_nettype wire

// *** sim/rgd_top_assertions.sv ***
// Port-level assertions for the receive gain decoder.
`timescale 1ns/10ps
`default_nettype none
`include "rgd_map.vh"
module rgd_chk #(
  parameter TW = 8
) (
  input wire logic                 pclk,
  input wire logic                 presetn,
  input wire logic                 psel,
  input wire logic                 penable,
  input wire logic                 pwrite,
  input wire logic [11:0]          paddr,
  input wire logic [3:0]           pstrb,
  input wire logic                 pslverr,
  input wire logic                 offset_valid,
  input wire logic [1:0]           lna_code,
  input wire logic [1:0]           mix_code,
  input wire logic [1:0]           filt1_code,
  input wire logic [1:0]           filt2_code,
  input wire logic [4:0]           vga_code,
  input wire logic [2:0]           filter_mode,
  input wire logic                 gain_change,
  input wire logic signed [TW-1:0] trim_i,
  input wire logic                 dc_busy
);
  // ****
  // Properties
  // ****
  default clocking @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  wire        wr    = psel && penable && pwrite;
  wire        g_wr  = wr && ((paddr == `RGD_ADDR_RXGAIN && pstrb[0]) || (paddr == `RGD_ADDR_RXCFG && |pstrb[1:0]));
  wire [12:0] codes = {lna_code, mix_code, filt1_code, filt2_code, vga_code};
  a_filt_equal: assert property (filt1_code == filt2_code)
    else $error("filter stage codes differ");
  a_vga_range: assert property (vga_code <= 5'h18)
    else $error("vga code above range");
  a_mix_range: assert property (mix_code <= 2'h2)
    else $error("mixer code above range");
  a_gain_pulse: assert property (g_wr |-> ##2 gain_change)
    else $error("gain write raised no gain change");
  a_pulse_cause: assert property (gain_change |-> $past(g_wr, 2))
    else $error("gain change without gain write");
  a_code_cause: assert property (!$stable(codes) |-> $past(wr) || $past(wr, 2))
    else $error("stage codes moved without a write");
  a_mode_cause: assert property ($changed(filter_mode) |-> $past(wr) || $past(wr, 2))
    else $error("filter mode moved without a write");
  a_busy_hold: assert property (dc_busy && !offset_valid |=> dc_busy)
    else $error("settling ended without a sample");
  a_busy_start: assert property ($rose(dc_busy) |-> $past(gain_change) || $past(gain_change, 2))
    else $error("offset loop started without gain change");
  a_trim_cause: assert property ($changed(trim_i) |-> $past(offset_valid) || $past(offset_valid, 2))
    else $error("trim moved without a sample");
  c_gain: cover property (gain_change);
  c_busy: cover property ($fell(dc_busy));
  c_err: cover property (psel && penable && pslverr);
endmodule
bind rgd_top rgd_chk #(.TW(TW)) u_chk (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pstrb(pstrb), .pslverr(pslverr), .offset_valid(offset_valid),
  .lna_code(lna_code), .mix_code(mix_code), .filt1_code(filt1_code), .filt2_code(filt2_code),
  .vga_code(vga_code), .filter_mode(filter_mode), .gain_change(gain_change), .trim_i(trim_i),
  .dc_busy(dc_busy));
`default_nettype wire

// *** sim/rgd_adc_model.sv ***
// Offset converter model feeding samples to the dc offset loop.
`timescale 1ns/10ps
`default_nettype none
module rgd_adc_model #(
  parameter AW  = 10,
  parameter GAP = 8
) (
  input  wire logic                 pclk,
  input  wire logic                 presetn,
  input  wire logic signed [AW-1:0] level_i,
  input  wire logic signed [AW-1:0] level_q,
  output var  logic                 offset_valid,
  output var  logic signed [AW-1:0] offset_i,
  output var  logic signed [AW-1:0] offset_q
);
  logic [7:0] cnt;
  // Periodic offset samples
  // Between samples the lines toggle, so stale data never passes for a sample.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt <= 8'h00;
      offset_valid <= 1'b0;
      offset_i <= {AW{1'b0}};
      offset_q <= {AW{1'b0}};
    end else begin
      cnt <= (cnt == GAP - 1) ? 8'h00 : cnt + 8'h01;
      offset_valid <= (cnt == GAP - 1);
      offset_i <= (cnt == GAP - 1) ? level_i : ~offset_i;
      offset_q <= (cnt == GAP - 1) ? level_q : ~offset_q;
    end
  end
endmodule
`default_nettype wire

// *** sim/tb_top.sv ***
// Self-checking bench for the receive gain decoder.
`timescale 1ns/10ps
`default_nettype none
`include "rgd_map.vh"
module tb_top;
  logic              pclk = 1'b0;
  logic              presetn = 1'b0;
  logic              psel = 1'b0;
  logic              penable = 1'b0;
  logic              pwrite = 1'b0;
  logic [11:0]       paddr = 12'h000;
  logic [31:0]       pwdata = 32'h0;
  logic [3:0]        pstrb = 4'h0;
  logic signed [9:0] level_i = 10'sh0;
  logic signed [9:0] level_q = 10'sh0;
  wire               pready, pslverr, offset_valid, gain_change, dc_busy;
  wire [31:0]        prdata;
  wire signed [9:0]  offset_i, offset_q;
  wire [1:0]         lna, mix, f1, f2;
  wire [4:0]         vga;
  wire [2:0]         fmode;
  wire signed [7:0]  trim_i, trim_q;
  integer            fails = 0, checked = 0, cyc = 0, seed = 32'h7254, i, n;
  logic [31:0]       rd;
  logic              er;
  logic [6:0]        rx;
  logic [4:0]        cal;
  logic [3:0]        ls, ms;
  logic [2:0]        md;
  logic [12:0]       e;
  always #2 pclk = ~pclk;
  rgd_top u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .offset_valid(offset_valid), .offset_i(offset_i), .offset_q(offset_q), .lna_code(lna), .mix_code(mix),
    .filt1_code(f1), .filt2_code(f2), .vga_code(vga), .filter_mode(fmode), .gain_change(gain_change),
    .trim_i(trim_i), .trim_q(trim_q), .dc_busy(dc_busy));
  rgd_adc_model u_adc (.pclk(pclk), .presetn(presetn), .level_i(level_i), .level_q(level_q),
    .offset_valid(offset_valid), .offset_i(offset_i), .offset_q(offset_q));
  // ****
  // Checking and bus tasks
  // ****
  function automatic [12:0] exp_codes(input [6:0] r, input [4:0] c, input [2:0] m, input [3:0] lt, mt);
    integer s, l, k, b, f;
    begin
      s = int'(r) - int'(c) + ((m == `RGD_FMODE_GSM) ? 17 - 21 : 8 - 12);
      s = (s < 0) ? 0 : (s > 90) ? 90 : s;
      l = (s >= 48 + lt) + (s >= 54 + lt) + (s >= 60 + lt);
      k = (s >= 30 + mt) + (s >= 36 + mt);
      b = s - 6 * (l + k);
      b = (b < 0) ? 0 : b;
      f = (b >= 25) + (b >= 37) + (b >= 49);
      b = (b - 12 * f > 24) ? 24 : b - 12 * f;
      exp_codes = {l[1:0], k[1:0], f[1:0], f[1:0], b[4:0]};
    end
  endfunction
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      fails++;
    end
  endtask
  task automatic end_sim;
    $display("checked=%0d fails=%0d", checked, fails);
    if (fails == 0 && checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    pstrb <= w ? 4'hf : 4'h0;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      fails++;
      end_sim;
    end
  end
  initial begin
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    chk({lna, mix, f1, f2, vga, fmode}, 32'h0);
    apb(1'b0, `RGD_ADDR_DCCFG, 32'h0);
    chk(rd, 32'h1042);
    apb(1'b0, 12'h100, 32'h0);
    chk({rd[30:0], er}, 32'h1);
    apb(1'b1, `RGD_ADDR_STATUS, 32'hffff);
    chk({gain_change, er}, 32'h1);
    for (i = 0; i < 24; i++) begin
      rx = (i == 0) ? 7'h7f : (i == 1) ? 7'h00 : 7'($random(seed));
      cal = (i == 1) ? 5'h1f : (i == 0) ? 5'h00 : 5'($random(seed));
      md = 3'(i % 4);
      {ls, ms} = 8'($random(seed));
      apb(1'b1, `RGD_ADDR_STEPS, {24'h0, ls, ms});
      apb(1'b1, `RGD_ADDR_RXCFG, {21'h0, md, 3'h0, cal});
      apb(1'b1, `RGD_ADDR_RXGAIN, {25'h0, rx});
      @(posedge pclk);
      #1;
      chk({lna, mix, f1, f2, vga}, exp_codes(rx, cal, md, ls, ms));
      chk(gain_change, 1'b1);
      chk(fmode, md);
      apb(1'b0, `RGD_ADDR_RXCFG, 32'h0);
      chk(rd, {21'h0, md, 3'h0, cal});
      apb(1'b0, `RGD_ADDR_STATUS, 32'h0);
      e = exp_codes(rx, cal, md, ls, ms);
      chk(rd, {7'h0, 9'(int'(rx) - int'(cal) + ((md == `RGD_FMODE_GSM) ? 17 : 8)), 5'h03, e[12:9], e[6:0]});
    end
    level_i <= 10'sh064;
    level_q <= -10'sh064;
    apb(1'b1, `RGD_ADDR_RXGAIN, 32'h40);
    for (n = 0; n < 8 && dc_busy !== 1'b1; n++) @(posedge pclk);
    chk(dc_busy, 1'b1);
    for (n = 0; n < 400 && dc_busy !== 1'b0; n++) @(posedge pclk);
    chk({trim_q, trim_i}, 32'h7f80);
    repeat (40) @(posedge pclk);
    chk({trim_q, trim_i}, 32'h7f80);
    apb(1'b0, `RGD_ADDR_TRIM, 32'h0);
    chk(rd, 32'h7f80);
    level_i <= -10'sh064;
    level_q <= 10'sh064;
    apb(1'b1, `RGD_ADDR_DCCFG, 32'h1043);
    repeat (400) @(posedge pclk);
    chk({trim_q, trim_i}, 32'h807f);
    apb(1'b1, `RGD_ADDR_RXGAIN, 32'h41);
    repeat (2) @(posedge pclk);
    apb(1'b0, `RGD_ADDR_STATUS, 32'h0);
    chk(rd[13:11], 3'h3);
    for (n = 0; n < 400 && dc_busy !== 1'b0; n++) @(posedge pclk);
    apb(1'b0, `RGD_ADDR_STATUS, 32'h0);
    chk(rd[13:11], 3'h4);
    end_sim;
  end
endmodule
`default_nettype wire
